/* logic/fso_pkg.sv */
package fso_pkg;
	// Clock and logic execution cycle
	localparam int          CLK_PERIOD_NS    = 8;
	localparam int          LOGIC_CYCLE_NS   = 4000;
	localparam int          LOGIC_CYCLE_CLKS = LOGIC_CYCLE_NS / CLK_PERIOD_NS;
	localparam int          TICK_W           = $clog2(LOGIC_CYCLE_CLKS);
	localparam logic [TICK_W-1:0] TICK_LAST  = TICK_W'(LOGIC_CYCLE_CLKS - 1);

	// Module I/O width
	localparam int          NUM_IO        = 8;
	localparam int          SEL_W         = 3;
	localparam int          CNT_W         = 4;

	// Input count limits per variant
	localparam logic [CNT_W-1:0] MIN_INPUTS     = 4'h1;
	localparam logic [CNT_W-1:0] MAX_INPUTS     = 4'h8;
	localparam logic [CNT_W-1:0] MAX_INPUTS_BYP = 4'h7;

	// Bypass switch-on delay in logic cycles
	localparam int          BYP_CNT_W     = 2;
	localparam logic [BYP_CNT_W-1:0] BYP_ON_CYCLES = 2'h3;

	// Standard application response after bypass withdrawal, in logic cycles
	localparam int          GRACE_W       = 3;
	localparam logic [GRACE_W-1:0] APP_RESP_CYCLES = 3'h4;

	// Reset values
	localparam logic [NUM_IO-1:0] PHYS_RST = 8'h00;
endpackage : fso_pkg

/* logic/fast_shutoff.sv */
`timescale 1ns/1ps
// Function
// - The plain variant takes one to eight monitored inputs and the bypass variant one to seven.
// - The bypass variant works like the plain one except that one input slot is the bypass.
// - All monitored inputs and the shut-off output belong to this one I/O module.
// - The shut-off output is any output of this module not yet claimed by another instance.
// - A stop condition switches the physical output off directly, not tied to the logic cycle.
// - In the plain variant no downstream logic can prevent or delay the shut-off once triggered.
// - The selected physical output is dropped at once and downstream logic for it is ignored.
// - Stop is the inverse of the OR of two zone ANDs, and an unused second zone stays off.
// - While the bypass is effective a stop condition switches off neither output.
// - The bypass takes effect only after being high for three consecutive logic cycles.
// - With the bypass qualified the block output stays 1 and the physical output stays high.
// - After bypass withdrawal with a stop present, outputs drop only after the normal response.
// - The bypass input is not on the fast path and may come from logic or another module.
module fast_shutoff
	import fso_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic [NUM_IO-1:0] mon_in,
	input  wire logic              bypass_in,
	input  wire logic              bypass_variant,
	input  wire logic [CNT_W-1:0]  input_count,
	input  wire logic [NUM_IO-1:0] zone1_mask,
	input  wire logic [NUM_IO-1:0] zone2_mask,
	input  wire logic [SEL_W-1:0]  out_sel,
	input  wire logic [NUM_IO-1:0] claimed_outputs,
	input  wire logic [NUM_IO-1:0] downstream_in,
	output logic                   shutoff_out,
	output logic [NUM_IO-1:0]      phys_out,
	output logic                   bypass_active,
	output logic                   cfg_err
);

	logic [TICK_W-1:0]    tick_cnt_ff;
	logic                 tick_ff;
	logic [BYP_CNT_W-1:0] byp_cnt_ff;
	logic                 byp_eff_ff;
	logic [GRACE_W-1:0]   grace_ff;
	logic                 shutoff_ff;
	logic [NUM_IO-1:0]    phys_ff;
	logic                 byp_hold_ff;
	logic                 cfg_err_ff;
	logic [NUM_IO-1:0]    used_mask;
	logic [NUM_IO-1:0]    z1_sel;
	logic [NUM_IO-1:0]    z2_sel;
	logic                 zone1_ok;
	logic                 zone2_ok;
	logic                 stop_cond;
	logic                 count_ok;
	logic                 cfg_ok;
	logic                 byp_hold;
	logic                 fast_off;
	logic [BYP_CNT_W-1:0] nxt_byp_cnt;

	// Logic execution cycle enable
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			tick_cnt_ff <= '0;
			tick_ff     <= 1'b0;
		end else begin
			tick_ff     <= (tick_cnt_ff == TICK_LAST);
			tick_cnt_ff <= (tick_cnt_ff == TICK_LAST) ? '0 : tick_cnt_ff + 1'b1;
		end
	end

	// Only the first input_count slots of this module are monitored
	always_comb begin
		used_mask = '0;
		for (int i = 0; i < NUM_IO; i++) begin
			if (CNT_W'(i) < input_count) begin
				used_mask[i] = 1'b1;
			end
		end
	end

	// Bypass slot leaves one fewer monitored input
	assign count_ok = (input_count >= MIN_INPUTS) &&
		(input_count <= (bypass_variant ? MAX_INPUTS_BYP : MAX_INPUTS));
	assign cfg_ok   = count_ok && !claimed_outputs[out_sel];

	// An empty zone counts as deactivated, never as satisfied
	assign z1_sel    = zone1_mask & used_mask;
	assign z2_sel    = zone2_mask & used_mask;
	assign zone1_ok  = (|z1_sel) && (&(mon_in | ~z1_sel));
	assign zone2_ok  = (|z2_sel) && (&(mon_in | ~z2_sel));
	assign stop_cond = !(zone1_ok || zone2_ok);

	assign byp_hold = byp_eff_ff || (grace_ff != '0);
	// Raw inputs drive this with no wait for a tick; bad configuration fails safe
	assign fast_off = !cfg_ok || (stop_cond && !byp_hold);

	assign nxt_byp_cnt = (byp_cnt_ff == BYP_ON_CYCLES) ? byp_cnt_ff : byp_cnt_ff + 1'b1;

	// Bypass qualification, sampled only at logic cycles
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			byp_cnt_ff <= '0;
			byp_eff_ff <= 1'b0;
		end else if (tick_ff) begin
			if (bypass_in && bypass_variant) begin
				byp_cnt_ff <= nxt_byp_cnt;
				byp_eff_ff <= (nxt_byp_cnt == BYP_ON_CYCLES);
			end else begin
				byp_cnt_ff <= '0;
				byp_eff_ff <= 1'b0;
			end
		end
	end

	// Withdrawn bypass keeps the fast path off for the standard response time
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			grace_ff <= '0;
		end else if (tick_ff) begin
			if (byp_eff_ff && !(bypass_in && bypass_variant)) begin
				grace_ff <= APP_RESP_CYCLES;
			end else if (grace_ff != '0) begin
				grace_ff <= grace_ff - 1'b1;
			end
		end
	end

	// Block output
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			shutoff_ff <= 1'b0;
		end else if (fast_off) begin
			shutoff_ff <= 1'b0;
		end else if (tick_ff) begin
			shutoff_ff <= 1'b1;
		end
	end

	// Physical outputs; only the selected one is on the fast path
	for (genvar g = 0; g < NUM_IO; g++) begin : g_phys
		always_ff @(posedge clk_sys) begin
			if (!resetn) begin
				phys_ff[g] <= PHYS_RST[g];
			end else if (out_sel == SEL_W'(g) && fast_off) begin
				phys_ff[g] <= 1'b0;
			end else if (tick_ff) begin
				if (out_sel == SEL_W'(g)) begin
					phys_ff[g] <= byp_hold || downstream_in[g];
				end else begin
					phys_ff[g] <= downstream_in[g];
				end
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			byp_hold_ff <= 1'b0;
			cfg_err_ff  <= 1'b0;
		end else begin
			byp_hold_ff <= byp_hold;
			cfg_err_ff  <= !cfg_ok;
		end
	end

	assign shutoff_out   = shutoff_ff;
	assign phys_out      = phys_ff;
	assign bypass_active = byp_hold_ff;
	assign cfg_err       = cfg_err_ff;

	// Checks
	a_tick_spacing: assert property (@(posedge clk_sys) disable iff (!resetn)
		tick_ff |=> !tick_ff)
		else $error("logic cycle enable repeated");
	a_fast_block_off: assert property (@(posedge clk_sys) disable iff (!resetn)
		(cfg_ok && stop_cond && !byp_hold) |=> !shutoff_out)
		else $error("block output not off after stop");
	a_fast_phys_off: assert property (@(posedge clk_sys) disable iff (!resetn)
		(cfg_ok && stop_cond && !byp_hold) |=> !phys_out[$past(out_sel)])
		else $error("physical output not off after stop");
	a_byp_three_cyc: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(byp_eff_ff) |-> ($past(byp_cnt_ff) == 2'h2) && $past(tick_ff))
		else $error("bypass qualified too early");
	a_byp_keeps_on: assert property (@(posedge clk_sys) disable iff (!resetn)
		(byp_eff_ff && cfg_ok && shutoff_out) |=> shutoff_out)
		else $error("bypassed output dropped");
	a_byp_phys_high: assert property (@(posedge clk_sys) disable iff (!resetn)
		(tick_ff && byp_eff_ff && cfg_ok && $stable(out_sel)) |=> phys_out[out_sel])
		else $error("physical output low under bypass");
	a_grace_load: assert property (@(posedge clk_sys) disable iff (!resetn)
		$fell(byp_eff_ff) |-> (grace_ff == APP_RESP_CYCLES))
		else $error("response delay not loaded on withdrawal");
	a_zone_clear_on: assert property (@(posedge clk_sys) disable iff (!resetn)
		(tick_ff && !fast_off) |=> shutoff_out)
		else $error("block output not restored");
	a_bad_cfg_off: assert property (@(posedge clk_sys) disable iff (!resetn)
		!cfg_ok |=> (!shutoff_out && cfg_err))
		else $error("invalid configuration not safe");
	a_plain_no_byp: assert property (@(posedge clk_sys) disable iff (!resetn)
		(tick_ff && !bypass_variant) |=> (byp_cnt_ff == '0))
		else $error("plain variant counted a bypass");
	a_short_byp: assert property (@(posedge clk_sys) disable iff (!resetn)
		(tick_ff && !(bypass_in && bypass_variant)) |=> !byp_eff_ff)
		else $error("bypass kept without request");
	a_grace_count: assert property (@(posedge clk_sys) disable iff (!resetn)
		(tick_ff && !byp_eff_ff && (grace_ff != '0)) |=> (grace_ff == $past(grace_ff) - 1'b1))
		else $error("response delay not counting down");
	a_byp_flag_lag: assert property (@(posedge clk_sys) disable iff (!resetn)
		$past(resetn) |-> (bypass_active == $past(byp_hold)))
		else $error("bypass flag does not follow hold");
	a_cfg_flag_lag: assert property (@(posedge clk_sys) disable iff (!resetn)
		$past(resetn) |-> (cfg_err == !$past(cfg_ok)))
		else $error("configuration flag does not follow check");

	c_fast_trip: cover property (@(posedge clk_sys) disable iff (!resetn)
		shutoff_out ##1 !shutoff_out);
	c_byp_qualify: cover property (@(posedge clk_sys) disable iff (!resetn)
		$rose(byp_eff_ff) && stop_cond);
	c_grace_expire: cover property (@(posedge clk_sys) disable iff (!resetn)
		(grace_ff == 3'h1) && tick_ff && stop_cond);
	c_plain_ignore: cover property (@(posedge clk_sys) disable iff (!resetn)
		tick_ff && bypass_in && !bypass_variant);

endmodule : fast_shutoff

/* verif/sensor_bank.sv */
`timescale 1ns/1ps
// Safety sensors wired to the same I/O module; a set trip bit opens that contact
module sensor_bank (
	input  wire logic [7:0] trip_mask,
	output logic      [7:0] mon_in
);
	assign mon_in = ~trip_mask;
endmodule : sensor_bank

/* verif/fast_shutoff_tb.sv */
`timescale 1ns/1ps
module fast_shutoff_tb;
	import fso_pkg::*;
	typedef struct {logic [3:0] c; logic [7:0] z1, z2, tr; logic run;} row_t;
	logic              clk_sys = 0, resetn = 0, bypass_in = 0, bypass_variant = 0;
	logic [CNT_W-1:0]  input_count = 4'h8;
	logic [NUM_IO-1:0] trip_mask = 8'h00, zone1_mask = 8'hff, zone2_mask = 8'h00;
	logic [NUM_IO-1:0] claimed_outputs = 8'h00, downstream_in = 8'hff, mon_in, phys_out;
	logic [SEL_W-1:0]  out_sel = 3'h5;
	logic              shutoff_out, bypass_active, cfg_err;
	int                num_errors = 0, checks = 0;
	row_t rows[6] = '{'{4'h8, 8'hff, 8'h00, 8'h80, 0}, '{4'h4, 8'h03, 8'h0c, 8'h01, 1},
		'{4'h4, 8'h03, 8'h0c, 8'h05, 0}, '{4'h2, 8'h03, 8'h00, 8'h04, 1},
		'{4'h1, 8'h01, 8'h00, 8'h01, 0}, '{4'h8, 8'hf0, 8'h0f, 8'h11, 0}};
	always #4 clk_sys = ~clk_sys;
	sensor_bank sb (.trip_mask(trip_mask), .mon_in(mon_in));
	fast_shutoff dut (.clk_sys(clk_sys), .resetn(resetn), .mon_in(mon_in),
		.bypass_in(bypass_in), .bypass_variant(bypass_variant), .input_count(input_count),
		.zone1_mask(zone1_mask), .zone2_mask(zone2_mask), .out_sel(out_sel),
		.claimed_outputs(claimed_outputs), .downstream_in(downstream_in),
		.shutoff_out(shutoff_out), .phys_out(phys_out), .bypass_active(bypass_active),
		.cfg_err(cfg_err));
	task automatic chk1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: bit got %b want %b", $time, got, exp);
		end
	endtask : chk1
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: byte got %h want %h", $time, got, exp);
		end
	endtask : chk8
	// Waits n falling clock edges; callers pick n against the 500-clock logic cycle
	task automatic clks(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : clks
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	task automatic cfg_case(input logic [3:0] c, input logic v, input logic [7:0] cl);
		input_count = c;
		bypass_variant = v;
		claimed_outputs = cl;
		clks(2);
		chk1(cfg_err, 1'b1);
		chk1(shutoff_out, 1'b0);
	endtask : cfg_case
	initial begin
		#(8 * 40000);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		clks(8);
		chk8(phys_out, PHYS_RST);
		chk1(shutoff_out, 1'b0);
		resetn = 1;
		$display("reset test done");
		foreach (rows[i]) begin
			{input_count, zone1_mask, zone2_mask, trip_mask} = {rows[i].c, rows[i].z1, rows[i].z2, 8'h00};
			clks(510);
			chk1(shutoff_out, 1'b1);
			trip_mask = rows[i].tr;
			clks(1);
			chk1(shutoff_out, rows[i].run);
			chk1(phys_out[5], rows[i].run);
		end
		$display("zone table done");
		// Plain variant must ignore even a long bypass request
		trip_mask = 8'h00;
		bypass_in = 1;
		clks(1510);
		chk1(bypass_active, 1'b0);
		chk1(shutoff_out, 1'b1);
		trip_mask = 8'h11;
		clks(1);
		chk1(shutoff_out, 1'b0);
		chk1(phys_out[5], 1'b0);
		bypass_in = 0;
		$display("plain bypass test done");
		cfg_case(4'h0, 1'b0, 8'h00);
		cfg_case(4'h8, 1'b1, 8'h00);
		cfg_case(4'h7, 1'b1, 8'h20);
		$display("config test done");
		{claimed_outputs, zone1_mask, zone2_mask, trip_mask} = 32'h007f0000;
		clks(510);
		chk1(cfg_err, 1'b0);
		chk1(shutoff_out, 1'b1);
		// A 1000-clock window holds exactly two ticks: too short to qualify
		bypass_in = 1;
		clks(1000);
		bypass_in = 0;
		downstream_in = 8'h00;
		trip_mask = 8'h01;
		clks(1);
		chk1(shutoff_out, 1'b0);
		chk1(phys_out[5], 1'b0);
		// Keep bypass low across a tick so qualification restarts from zero
		clks(500);
		chk1(bypass_active, 1'b0);
		chk1(shutoff_out, 1'b0);
		trip_mask = 8'h00;
		bypass_in = 1;
		clks(1000);
		chk1(bypass_active, 1'b0);
		chk1(shutoff_out, 1'b1);
		clks(501);
		chk1(bypass_active, 1'b1);
		trip_mask = 8'h01;
		clks(1010);
		chk1(shutoff_out, 1'b1);
		chk1(phys_out[5], 1'b1);
		bypass_in = 0;
		clks(1500);
		chk1(shutoff_out, 1'b1);
		chk1(bypass_active, 1'b1);
		clks(1600);
		chk1(shutoff_out, 1'b0);
		chk1(phys_out[5], 1'b0);
		chk1(bypass_active, 1'b0);
		$display("bypass test done");
		resetn = 0;
		clks(2);
		chk8(phys_out, PHYS_RST);
		chk1(shutoff_out, 1'b0);
		chk1(bypass_active, 1'b0);
		chk1(cfg_err, 1'b0);
		resetn = 1;
		clks(510);
		chk1(shutoff_out, 1'b0);
		chk1(cfg_err, 1'b0);
		$display("mid reset test done");
		tally_and_finish();
	end
endmodule : fast_shutoff_tb
